/* src/mpi_interpolator.sv */
// microstep interpolator: step timing, indexer, custom profile, current scaling, chopping
`timescale 1ns/1ns
`default_nettype none

module mpi_interpolator
	import mpi_pkg::*;
#(
	parameter int unsigned STEP_SAT_CYCLES = MPI_STEP_SAT_CYC,
	parameter int unsigned MS_CYCLES       = MPI_MS_CYC
)(
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       step_pin,
	input  wire logic       dir_pin,
	input  wire logic       pin_mode,
	input  wire logic [1:0] coil_trip,
	input  wire logic       reg_wr_en,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic      [7:0] coil_a_ref,
	output logic            coil_a_pos,
	output logic      [7:0] coil_b_ref,
	output logic            coil_b_pos,
	output logic      [1:0] bridge_drive,
	output logic            vref_int_sel,
	output logic            standstill
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             step_s1;
		logic             step_s2;
		logic             step_prev;
		logic             dir_s1;
		logic             dir_s2;
		logic [1:0]       trip_s1;
		logic [1:0]       trip_s2;
		logic [7:0]       ctrl;
		logic [7:0]       run;
		logic [7:0]       hold;
		logic [5:0]       dly;
		logic [3:0]       base_res;
		logic [7:0][7:0]  pts;
		logic [7:0][7:0]  shd;
		logic             shd_pend;
		logic [9:0]       pos;
		logic [9:0]       tgt;
		logic [23:0]      ivl_cnt;
		logic [23:0]      sub_per;
		logic [23:0]      sub_cnt;
		logic [8:0]       remain;
		logic             dir_lat;
		logic [16:0]      ms_cnt;
		logic [9:0]       still_ms;
		logic             stsl;
		logic [1:0]       drive;
		logic [1:0][10:0] off_cnt;
		logic [7:0]       rdata;
		logic [7:0]       a_ref;
		logic [7:0]       b_ref;
		logic             a_pos;
		logic             b_pos;
	} mpi_state_t;

	mpi_state_t st_ff;
	mpi_state_t nxt_st;

	// ----------------------------------------------------------------
	// profile lookups, one per coil
	// ----------------------------------------------------------------
	logic [7:0][7:0] prof_pts;
	logic [7:0]      a_idx;
	logic [7:0]      b_idx;
	logic [7:0]      a_mag;
	logic [7:0]      b_mag;

	// custom points only once latched into the shadow copy;
	// both coils read the same point set, so a shadow update reaches them in one cycle
	assign prof_pts = st_ff.ctrl[MPI_CTRL_CUSTOM_EN] ? st_ff.shd : MPI_SINE_PTS;
	// odd quadrants run the quarter wave backwards; coil b is the complement
	assign a_idx    = st_ff.pos[8] ? ~st_ff.pos[7:0] : st_ff.pos[7:0];
	assign b_idx    = ~a_idx;

	mpi_profile_lerp u_lerp_a (
		.pts (prof_pts),
		.idx (a_idx),
		.mag (a_mag)
	);

	mpi_profile_lerp u_lerp_b (
		.pts (prof_pts),
		.idx (b_idx),
		.mag (b_mag)
	);

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	logic        step_edge;
	logic        auto_en;
	logic [1:0]  lvl;
	logic [3:0]  res_c;
	logic [3:0]  base_log;
	logic [3:0]  shift;
	logic [9:0]  inc;
	logic [9:0]  fine;
	logic [23:0] per;
	logic        ms_tick;
	logic        stopped;
	logic [7:0]  hold_eff;
	logic [7:0]  scale;
	logic [16:0] a_prod;
	logic [16:0] b_prod;
	logic [9:0]  dly_ms;

	always_comb begin
		nxt_st    = st_ff;
		auto_en   = st_ff.ctrl[MPI_CTRL_AUTO_EN];
		lvl       = st_ff.ctrl[MPI_CTRL_LVL_LO +: 2];
		res_c     = (st_ff.base_res > 4'(MPI_MAX_BASE_RES)) ? 4'(MPI_MAX_BASE_RES) : st_ff.base_res;
		inc       = MPI_FULL_STEP >> res_c;
		base_log  = 4'(MPI_MAX_BASE_RES) - res_c;
		// level read every edge, so it may change during motion
		shift     = (base_log > {2'b00, lvl}) ? (base_log - {2'b00, lvl}) : 4'h0;
		fine      = inc >> shift;
		per       = st_ff.ivl_cnt >> shift; // interval divided by ratio
		step_edge = st_ff.step_s2 & ~st_ff.step_prev;
		ms_tick   = (st_ff.ms_cnt == 17'(MS_CYCLES - 1));
		stopped   = (st_ff.remain == 9'h000) && (st_ff.still_ms != 10'h000);
		dly_ms    = 10'(st_ff.dly * 10'(MPI_STSL_UNIT_MS));
		hold_eff  = (st_ff.hold < st_ff.run) ? st_ff.hold : st_ff.run;
		scale     = 8'h00;
		a_prod    = 17'h0_0000;
		b_prod    = 17'h0_0000;

		// pin synchronisers; only the second stage feeds logic
		nxt_st.step_s1   = step_pin;
		nxt_st.step_s2   = st_ff.step_s1;
		nxt_st.step_prev = st_ff.step_s2;
		nxt_st.dir_s1    = dir_pin;
		nxt_st.dir_s2    = st_ff.dir_s1;
		nxt_st.trip_s1   = coil_trip;
		nxt_st.trip_s2   = st_ff.trip_s1;

		// register writes; unmapped offsets are ignored
		if (reg_wr_en) begin
			unique case (reg_addr)
				MPI_OFS_CTRL:     nxt_st.ctrl     = reg_wdata;
				MPI_OFS_RUN:      nxt_st.run      = reg_wdata;
				MPI_OFS_HOLD:     nxt_st.hold     = reg_wdata;
				MPI_OFS_STSL_DLY: nxt_st.dly      = reg_wdata[5:0];
				MPI_OFS_BASE_RES: nxt_st.base_res = reg_wdata[3:0];
				default: begin
					if (reg_addr >= MPI_OFS_PT_FIRST && reg_addr <= MPI_OFS_PT_LAST) begin
						nxt_st.pts[3'(reg_addr - MPI_OFS_PT_FIRST)] = reg_wdata;
						nxt_st.shd_pend = 1'b1;
					end
				end
			endcase
		end

		// register reads, one cycle late; unmapped reads give zero
		unique case (reg_addr)
			MPI_OFS_CTRL:     nxt_st.rdata = st_ff.ctrl;
			MPI_OFS_RUN:      nxt_st.rdata = st_ff.run;
			MPI_OFS_HOLD:     nxt_st.rdata = st_ff.hold;
			MPI_OFS_STSL_DLY: nxt_st.rdata = {2'b00, st_ff.dly};
			MPI_OFS_BASE_RES: nxt_st.rdata = {4'h0, st_ff.base_res};
			MPI_OFS_STATUS:   nxt_st.rdata = {4'h0, st_ff.pos[9:8], (st_ff.remain != 9'h000), st_ff.stsl};
			MPI_OFS_POS:      nxt_st.rdata = st_ff.pos[7:0];
			default: begin
				if (reg_addr >= MPI_OFS_PT_FIRST && reg_addr <= MPI_OFS_PT_LAST) begin
					nxt_st.rdata = st_ff.pts[3'(reg_addr - MPI_OFS_PT_FIRST)];
				end else begin
					nxt_st.rdata = 8'h00;
				end
			end
		endcase

		// shadow copy only at a full-step boundary or at rest, so a quadrant never mixes old and new
		if (st_ff.shd_pend && ((st_ff.pos[7:0] == 8'h00) || stopped)) begin
			nxt_st.shd      = st_ff.pts;
			nxt_st.shd_pend = 1'b0;
		end

		// step interval counter, saturating at the slowest legal rate;
		// a gap longer than that reads as the slowest rate, so a restart after a pause
		// creeps through its first interval instead of racing through it
		if (st_ff.ivl_cnt < 24'(STEP_SAT_CYCLES)) begin
			nxt_st.ivl_cnt = st_ff.ivl_cnt + 24'h00_0001;
		end

		// fine stepping inside an interval
		if (auto_en && st_ff.remain != 9'h000) begin
			if (st_ff.sub_cnt + 24'h00_0001 >= st_ff.sub_per) begin
				nxt_st.pos     = st_ff.dir_lat ? st_ff.pos + fine : st_ff.pos - fine;
				nxt_st.remain  = st_ff.remain - 9'h001;
				nxt_st.sub_cnt = 24'h00_0000;
			end else begin
				nxt_st.sub_cnt = st_ff.sub_cnt + 24'h00_0001;
			end
		end
		// when remain reaches zero the position simply stays until the next edge

		// leaving auto mode: keep the interpolated position as the counted one and step plainly
		if (!auto_en) begin
			nxt_st.remain = 9'h000;
			nxt_st.tgt    = st_ff.pos;
		end

		if (step_edge) begin
			nxt_st.ivl_cnt = 24'h00_0000;
			nxt_st.dir_lat = st_ff.dir_s2;
			if (auto_en) begin
				// unfinished interpolation jumps to the counted position
				nxt_st.pos     = st_ff.tgt;
				nxt_st.tgt     = st_ff.dir_s2 ? st_ff.tgt + inc : st_ff.tgt - inc;
				nxt_st.remain  = 9'(9'h001 << shift);
				// rate derived from the interval just measured
				nxt_st.sub_per = (per == 24'h00_0000) ? 24'h00_0001 : per;
				nxt_st.sub_cnt = 24'h00_0000;
			end else begin
				nxt_st.pos = st_ff.dir_s2 ? st_ff.pos + inc : st_ff.pos - inc;
				nxt_st.tgt = nxt_st.pos;
			end
		end

		// millisecond enable and time since the last edge
		nxt_st.ms_cnt = ms_tick ? 17'h0_0000 : st_ff.ms_cnt + 17'h0_0001;
		if (step_edge) begin
			nxt_st.still_ms = 10'h000;
		end else if (ms_tick && st_ff.still_ms != 10'h3ff) begin
			nxt_st.still_ms = st_ff.still_ms + 10'h001;
		end

		// standstill saving: delay zero is reserved and never enters;
		// a step edge wins over a set in the same cycle, so a late pulse never leaves hold level on
		if (step_edge || !st_ff.ctrl[MPI_CTRL_STSL_EN]) begin
			nxt_st.stsl = 1'b0;
		end else if (st_ff.remain == 9'h000 && st_ff.dly != 6'h00 && st_ff.still_ms >= dly_ms) begin
			nxt_st.stsl = 1'b1;
		end

		// reference scaling; pin mode follows the external reference alone;
		// the hold level is capped at the run level, so entering standstill never raises the current
		if (pin_mode) begin
			scale = 8'hff;
		end else if (st_ff.stsl) begin
			scale = hold_eff;
		end else begin
			scale = st_ff.run;
		end
		// code n gives (n+1)/256 of full scale
		a_prod        = 17'(a_mag * ({1'b0, scale} + 9'h001));
		b_prod        = 17'(b_mag * ({1'b0, scale} + 9'h001));
		nxt_st.a_ref  = a_prod[15:8];
		nxt_st.b_ref  = b_prod[15:8];
		nxt_st.a_pos  = ~st_ff.pos[9];
		nxt_st.b_pos  = (st_ff.pos[9:8] == 2'b00) || (st_ff.pos[9:8] == 2'b11);

		// per-coil chopping: trip ends the drive phase for a fixed off time;
		// the trip is a level, so one still high when the off time ends cuts the next drive phase
		// short after the two synchroniser stages
		for (int k = 0; k < 2; k++) begin
			if (st_ff.drive[k]) begin
				if (st_ff.trip_s2[k]) begin
					nxt_st.drive[k]   = 1'b0;
					nxt_st.off_cnt[k] = MPI_OFF_CYC;
				end
			end else if (st_ff.off_cnt[k] <= 11'h001) begin
				nxt_st.drive[k]   = 1'b1;
				nxt_st.off_cnt[k] = 11'h000;
			end else begin
				nxt_st.off_cnt[k] = st_ff.off_cnt[k] - 11'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// bridges start in drive so regulation runs from the first cycle, and the step
	// edge detector starts low like the idle pin, so release never shows a false step
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_ff          <= '0;
			st_ff.ctrl     <= MPI_RST_CTRL;
			st_ff.run      <= MPI_RST_RUN;
			st_ff.hold     <= MPI_RST_HOLD;
			st_ff.dly      <= MPI_RST_STSL_DLY;
			st_ff.base_res <= MPI_RST_BASE_RES;
			st_ff.pos      <= MPI_RST_POS;
			st_ff.tgt      <= MPI_RST_POS;
			st_ff.drive    <= 2'b11;
			st_ff.sub_per  <= 24'h00_0001;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign reg_rdata    = st_ff.rdata;
	assign coil_a_ref   = st_ff.a_ref;
	assign coil_a_pos   = st_ff.a_pos;
	assign coil_b_ref   = st_ff.b_ref;
	assign coil_b_pos   = st_ff.b_pos;
	assign bridge_drive = st_ff.drive;
	// pin mode has no register path, so the pin reference always wins there
	assign vref_int_sel = st_ff.ctrl[MPI_CTRL_VREF_INT] & ~pin_mode;
	assign standstill   = st_ff.stsl;

endmodule

`default_nettype wire

/* src/mpi_pkg.sv */
// package: register map, reset values and timing constants of the microstep interpolator
package mpi_pkg;

	// ----------------------------------------------------------------
	// register offsets (4-bit write/read port)
	// ----------------------------------------------------------------
	localparam logic [3:0] MPI_OFS_CTRL     = 4'h0;
	localparam logic [3:0] MPI_OFS_RUN      = 4'h1;
	localparam logic [3:0] MPI_OFS_HOLD     = 4'h2;
	localparam logic [3:0] MPI_OFS_STSL_DLY = 4'h3;
	localparam logic [3:0] MPI_OFS_BASE_RES = 4'h4;
	localparam logic [3:0] MPI_OFS_STATUS   = 4'h5;
	localparam logic [3:0] MPI_OFS_PT_FIRST = 4'h6;
	localparam logic [3:0] MPI_OFS_PT_LAST  = 4'hd;
	localparam logic [3:0] MPI_OFS_POS      = 4'he;

	// ----------------------------------------------------------------
	// control register field positions
	// ----------------------------------------------------------------
	localparam int MPI_CTRL_AUTO_EN   = 0;
	localparam int MPI_CTRL_LVL_LO    = 1;
	localparam int MPI_CTRL_STSL_EN   = 3;
	localparam int MPI_CTRL_CUSTOM_EN = 4;
	localparam int MPI_CTRL_VREF_INT  = 5;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] MPI_RST_CTRL     = 8'h00;
	localparam logic [7:0] MPI_RST_RUN      = 8'hff;
	localparam logic [7:0] MPI_RST_HOLD     = 8'h80;
	localparam logic [5:0] MPI_RST_STSL_DLY = 6'h01;
	localparam logic [3:0] MPI_RST_BASE_RES = 4'h0;
	localparam logic [9:0] MPI_RST_POS      = 10'h080;
	localparam logic [7:0] MPI_RST_POINT    = 8'h00;

	// default sinusoidal points at 11.25 deg steps, used when custom is off
	localparam logic [7:0][7:0] MPI_SINE_PTS = {8'hff, 8'hfa, 8'hec, 8'hd4, 8'hb4, 8'h8e, 8'h62, 8'h32};

	// ----------------------------------------------------------------
	// geometry and timing
	// ----------------------------------------------------------------
	localparam int          MPI_MAX_BASE_RES = 8;
	localparam logic [9:0]  MPI_FULL_STEP    = 10'h100;
	localparam int          MPI_CLK_HZ       = 100000000;
	localparam int          MPI_CLK_NS       = 10;
	localparam int          MPI_STEP_MIN_HZ  = 10;
	localparam int          MPI_STEP_SAT_CYC = MPI_CLK_HZ / MPI_STEP_MIN_HZ;
	localparam int          MPI_MS_US        = 1000;
	localparam int          MPI_MS_CYC       = MPI_MS_US * (MPI_CLK_HZ / 1000000);
	localparam int          MPI_STSL_UNIT_MS = 16;
	localparam int          MPI_T_OFF_NS     = 20000;
	localparam logic [10:0] MPI_OFF_CYC      = 11'((MPI_T_OFF_NS + MPI_CLK_NS - 1) / MPI_CLK_NS);

endpackage

/* src/mpi_profile_lerp.sv */
// piecewise-linear expansion of nine quarter-wave points into 256 positions
`timescale 1ns/1ns
`default_nettype none

module mpi_profile_lerp
	import mpi_pkg::*;
(
	input  wire logic [7:0][7:0] pts,
	input  wire logic [7:0]      idx,
	output logic      [7:0]      mag
);

	logic        [8:0]  t_ext;
	logic        [3:0]  seg;
	logic        [4:0]  frac;
	logic        [7:0]  lo;
	logic        [7:0]  hi;
	logic signed [8:0]  diff;
	logic signed [14:0] prod;
	logic        [14:0] sum;

	// ----------------------------------------------------------------
	// interpolation
	// ----------------------------------------------------------------
	// stretch 0..255 onto 0..256 so the last index lands on the 90 deg point
	always_comb begin
		t_ext = {1'b0, idx} + {8'h00, idx[7]};
		seg   = t_ext[8:5];
		frac  = t_ext[4:0];
		lo    = (seg == 4'h0) ? 8'h00 : pts[3'(seg - 4'h1)]; // point at 0 deg is zero
		hi    = (seg == 4'h8) ? pts[7] : pts[seg[2:0]];
		diff  = $signed({1'b0, hi}) - $signed({1'b0, lo});
		prod  = 15'(diff * $signed({1'b0, frac}));
		sum   = {2'b00, lo, 5'b0_0000} + 15'(prod); // linear between neighbours
		mag   = (seg == 4'h8) ? pts[7] : sum[12:5];
	end

endmodule

`default_nettype wire

/* tb/mpi_interpolator_sva.sv */
// checker: port-level properties of the microstep interpolator
`timescale 1ns/1ns
`default_nettype none
module mpi_interpolator_sva
	import mpi_pkg::*;
#(
	parameter int unsigned MS_CYCLES = MPI_MS_CYC
)(
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic       step_pin,
	input wire logic       pin_mode,
	input wire logic [1:0] coil_trip,
	input wire logic       reg_wr_en,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] bridge_drive,
	input wire logic       vref_int_sel,
	input wire logic       standstill
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	logic [11:0] off_cnt_ff;
	logic [31:0] quiet_cnt_ff;
	// --------------------------------
	// helper counters
	// --------------------------------
	// cycles in decay and since the step pin was last high; saturate so a long run never wraps
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			off_cnt_ff   <= 12'h000;
			quiet_cnt_ff <= 32'h0000_0000;
		end else begin
			off_cnt_ff   <= bridge_drive[0] ? 12'h000 : off_cnt_ff + 12'(~&off_cnt_ff);
			quiet_cnt_ff <= step_pin ? 32'h0000_0000 : quiet_cnt_ff + 32'(~&quiet_cnt_ff);
		end
	end
	AST_RUN_RDBK: assert property (
		(reg_wr_en && reg_addr == MPI_OFS_RUN) ##1 (!reg_wr_en && reg_addr == MPI_OFS_RUN)
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("run scale readback differs");
	AST_HOLD_RDBK: assert property (
		(reg_wr_en && reg_addr == MPI_OFS_HOLD) ##1 (!reg_wr_en && reg_addr == MPI_OFS_HOLD)
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("hold level readback differs");
	AST_VREF_PIN: assert property (
		pin_mode |-> !vref_int_sel) else $error("internal reference selected in pin mode");
	AST_VREF_FOLLOW: assert property (
		(reg_wr_en && reg_addr == MPI_OFS_CTRL) ##1 !pin_mode |-> vref_int_sel == $past(reg_wdata[5]))
		else $error("internal reference select does not follow control write");
	AST_CHOP_TRIP: assert property (
		coil_trip[0] [*4] |-> ##[0:1] !bridge_drive[0]) else $error("bridge keeps driving after trip");
	AST_OFF_TIME: assert property (
		$rose(bridge_drive[0]) |-> off_cnt_ff >= 12'h7cf && off_cnt_ff <= 12'h7d1)
		else $error("decay time is not the off time");
	AST_STSL_EXIT: assert property (
		$rose(step_pin) |-> ##[1:6] !standstill) else $error("standstill not left on step edge");
	AST_STSL_DELAY: assert property (
		$rose(standstill) |-> quiet_cnt_ff >= 16 * MS_CYCLES - 20) else $error("standstill entered too early");
	cover property ($rose(standstill));
	cover property ($fell(bridge_drive[1]));
	cover property (reg_wr_en && reg_addr == MPI_OFS_CTRL && reg_wdata[0]);
endmodule
bind mpi_interpolator mpi_interpolator_sva #(.MS_CYCLES(MS_CYCLES)) i_sva (
	.clk_sys(clk_sys), .arst_n(arst_n), .step_pin(step_pin), .pin_mode(pin_mode), .coil_trip(coil_trip),
	.reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.bridge_drive(bridge_drive), .vref_int_sel(vref_int_sel), .standstill(standstill));
`default_nettype wire

/* tb/mpi_step_host.sv */
// step and direction source standing in for the system controller
`timescale 1ns/1ns
`default_nettype none
module mpi_step_host (
	input  wire logic       clk_sys,
	input  wire logic       fire,
	input  wire logic       fwd,
	input  wire logic [3:0] hi_cyc,
	output logic            step_pin,
	output logic            dir_pin
);
	logic [4:0] cnt_ff   = 5'h00;
	logic [4:0] wid_ff   = 5'h04;
	logic       step_ff  = 1'b0;
	logic       dir_ff   = 1'b1;
	// direction settles first, then a high phase of four to fifteen cycles;
	// pulse spacing within the allowed rate is left to whoever fires
	always @(posedge clk_sys) begin
		if (fire && cnt_ff == 5'h00) begin
			dir_ff <= fwd;
			wid_ff <= {1'b0, hi_cyc | 4'h4};
			cnt_ff <= 5'h14;
		end else if (cnt_ff != 5'h00) begin
			cnt_ff <= cnt_ff - 5'h01;
		end
		step_ff <= cnt_ff != 5'h00 && cnt_ff <= wid_ff;
	end
	assign step_pin = step_ff;
	assign dir_pin  = dir_ff;
endmodule
`default_nettype wire

/* tb/tb_microstep_profile_interpolator.sv */
// testbench: directed and random runs of the microstep interpolator
`timescale 1ns/1ns
`default_nettype none
module tb_microstep_profile_interpolator
	import mpi_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        arst_n, pin_mode, reg_wr_en, fire, fwd, step_pin, dir_pin, vref_int_sel, standstill;
	logic        coil_a_pos, coil_b_pos;
	logic [1:0]  coil_trip, bridge_drive;
	logic [3:0]  reg_addr, hi_cyc;
	logic [7:0]  reg_wdata, reg_rdata, coil_a_ref, coil_b_ref, rv, hv, d, p0;
	logic [7:0]  pt [0:8];
	logic [31:0] rnd;
	int          miscompares = 0;
	int          cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	// long counts shortened so the run stays brief
	mpi_interpolator #(.STEP_SAT_CYCLES(1000), .MS_CYCLES(10)) i_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .step_pin(step_pin), .dir_pin(dir_pin), .pin_mode(pin_mode),
		.coil_trip(coil_trip), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .coil_a_ref(coil_a_ref), .coil_a_pos(coil_a_pos), .coil_b_ref(coil_b_ref),
		.coil_b_pos(coil_b_pos), .bridge_drive(bridge_drive), .vref_int_sel(vref_int_sel),
		.standstill(standstill));
	mpi_step_host i_host (.clk_sys(clk_sys), .fire(fire), .fwd(fwd), .hi_cyc(hi_cyc), .step_pin(step_pin),
		.dir_pin(dir_pin));
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// reference magnitude times scale plus one, over 256
	function automatic logic [7:0] scl(input logic [7:0] m, input logic [7:0] s);
		return 8'((16'(m) * (16'(s) + 16'h0001)) >> 8);
	endfunction
	// every wait ends just past the edge so that sampled outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr_en <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		tick(1);
		v = reg_rdata;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] e, input string nm);
		rd(a, d);
		chk(nm, e, d);
	endtask
	// one step pulse with a random high width, then a quiet gap
	task automatic step(input logic f, input int gap);
		rnd = lfsr(rnd);
		@(posedge clk_sys);
		fwd    <= f;
		hi_cyc <= rnd[3:0];
		fire   <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
		tick(gap);
	endtask
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// watchdog, several times the expected run length
	initial begin
		tick(40000);
		miscompares++;
		$display("unexpected watchdog: run did not finish");
		stop_test();
	end
	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		rnd = 32'hb18f_a55f;
		arst_n = 1'b0;
		pin_mode = 1'b0;
		coil_trip = 2'b00;
		reg_wr_en = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		fire = 1'b0;
		fwd = 1'b1;
		hi_cyc = 4'h4;
		tick(16);
		@(posedge clk_sys) arst_n <= 1'b1;
		rc(MPI_OFS_RUN, 8'hff, "run_reset");
		rc(MPI_OFS_HOLD, 8'h80, "hold_reset");
		$display("test reset_values done");
		// custom points at exact breakpoints: a position, b mirrored
		wr(MPI_OFS_BASE_RES, 8'h03);
		pt[0] = 8'h00;
		for (int k = 1; k <= 8; k++) begin
			rnd = lfsr(rnd);
			pt[k] = rnd[7:0];
			wr(MPI_OFS_PT_FIRST + 4'(k - 1), pt[k]);
		end
		wr(MPI_OFS_CTRL, 8'h10);
		tick(30);
		for (int k = 3; k >= 0; k--) begin
			rnd = lfsr(rnd);
			rv = rnd[15:8];
			wr(MPI_OFS_RUN, rv);
			rc(MPI_OFS_RUN, rv, "run");
			step(1'b0, 340);
			chk("coil_a_ref", scl(pt[k], rv), coil_a_ref);
			chk("coil_b_ref", scl(pt[8 - k], rv), coil_b_ref);
			chk("signs", 8'h03, {6'h00, coil_a_pos, coil_b_pos});
			rc(MPI_OFS_POS, 8'(k * 32), "pos");
		end
		$display("test custom_walk done");
		wr(MPI_OFS_CTRL, 8'h20);
		tick(4);
		chk("sine_b", scl(MPI_SINE_PTS[7], rv), coil_b_ref);
		chk("vref_int_sel", 8'h01, {7'h00, vref_int_sel});
		@(posedge clk_sys) pin_mode <= 1'b1;
		tick(4);
		chk("pin_b", MPI_SINE_PTS[7], coil_b_ref);
		chk("vref_int_sel", 8'h00, {7'h00, vref_int_sel});
		@(posedge clk_sys) pin_mode <= 1'b0;
		rnd = lfsr(rnd);
		hv = rnd[7:0];
		wr(MPI_OFS_HOLD, hv);
		wr(MPI_OFS_CTRL, 8'h08);
		tick(250);
		chk("standstill", 8'h01, {7'h00, standstill});
		chk("hold_b", scl(MPI_SINE_PTS[7], hv < rv ? hv : rv), coil_b_ref);
		// first quadrant, nothing to interpolate, saving active
		rc(MPI_OFS_STATUS, 8'h01, "status_still");
		step(1'b1, 30);
		chk("standstill", 8'h00, {7'h00, standstill});
		$display("test scale_and_standstill done");
		// three steps per level; the last interval is cut short to look mid-way
		for (int lv = 0; lv < 4; lv++) begin
			rd(MPI_OFS_POS, p0);
			wr(MPI_OFS_CTRL, 8'h01 | 8'(lv << 1));
			step(1'b1, 400);
			step(1'b1, 400);
			step(1'b1, 200);
			rd(MPI_OFS_POS, d);
			chk("pos_mid", 8'h01, {7'h00, 8'(d - p0) > 8'h40 && 8'(d - p0) < 8'h60});
			tick(500);
			rc(MPI_OFS_POS, p0 + 8'h60, "pos_end");
		end
		rd(MPI_OFS_POS, p0);
		wr(MPI_OFS_CTRL, 8'h00);
		step(1'b1, 40);
		rc(MPI_OFS_POS, p0 + 8'h20, "pos_plain");
		// the walk has ended in the second quadrant: coil a positive, coil b negative
		chk("signs_q1", 8'h02, {6'h00, coil_a_pos, coil_b_pos});
		rc(MPI_OFS_STATUS, 8'h04, "status_q1");
		$display("test auto_levels done");
		@(posedge clk_sys) coil_trip <= 2'b11;
		tick(6);
		@(posedge clk_sys) coil_trip <= 2'b00;
		tick(1);
		chk("bridge_drive", 8'h00, {6'h00, bridge_drive});
		tick(1975);
		chk("bridge_drive", 8'h00, {6'h00, bridge_drive});
		tick(40);
		chk("bridge_drive", 8'h03, {6'h00, bridge_drive});
		$display("test chopping done");
		stop_test();
	end
endmodule
`default_nettype wire
